// ---- core/ccrb_pkg.sv ----
// constants and types for the caption route and bridge controller
package ccrb_pkg;

    localparam int BYTE_W = 8;
    localparam int CODE_W = 4;
    localparam int RATE_W = 3;
    localparam int NCH = 2;

    // route-select codes
    localparam logic [CODE_W-1:0] ROUTE_ENC_SPLIT = 4'h0;
    localparam logic [CODE_W-1:0] ROUTE_ENC_SER = 4'h1;
    localparam logic [CODE_W-1:0] ROUTE_ENC_ETH = 4'h2;
    localparam logic [CODE_W-1:0] ROUTE_SPLIT = 4'h3;
    localparam logic [CODE_W-1:0] ROUTE_SER_A = 4'h4;
    localparam logic [CODE_W-1:0] ROUTE_ETH_B = 4'h5;
    localparam logic [CODE_W-1:0] ROUTE_SER_B = 4'h6;
    localparam logic [CODE_W-1:0] ROUTE_ETH_A = 4'h7;
    localparam logic [CODE_W-1:0] ROUTE_DEC_A = 4'h8;
    localparam logic [CODE_W-1:0] ROUTE_DEC_B = 4'h9;

    // bridge-select codes
    localparam logic [CODE_W-1:0] BRG_NONE = 4'h0;
    localparam logic [CODE_W-1:0] BRG_AB = 4'h1;
    localparam logic [CODE_W-1:0] BRG_BA = 4'h2;
    localparam logic [CODE_W-1:0] BRG_AB_F1 = 4'h3;
    localparam logic [CODE_W-1:0] BRG_BA_F1 = 4'h4;
    localparam logic [CODE_W-1:0] BRG_AB_F2 = 4'h5;
    localparam logic [CODE_W-1:0] BRG_BA_F2 = 4'h6;

    localparam logic FIELD_1 = 1'b0;
    localparam logic FIELD_2 = 1'b1;
    localparam int CH_A = 0;
    localparam int CH_B = 1;

    typedef enum logic [1:0] {SRC_NONE, SRC_SER, SRC_ETH} ccrb_ins_src_type;
    typedef enum logic [1:0] {DEC_NONE, DEC_A, DEC_B} ccrb_dec_src_type;

    typedef struct packed {
        logic [NCH-1:0][BYTE_W-1:0] ins_data;
        logic [NCH-1:0] ins_vld;
        logic [NCH-1:0] ins_brg;
        logic [NCH-1:0] ins_xcode;
        logic [BYTE_W-1:0] ser_data;
        logic ser_vld;
        logic [BYTE_W-1:0] eth_data;
        logic eth_vld;
        logic [BYTE_W-1:0] ovl_data;
        logic ovl_vld;
        logic odd_from_a;
        logic even_from_b;
    } ccrb_state_type;

    localparam ccrb_state_type ST_RST = '0;

endpackage

// ---- core/ccrb_caption_route_bridge.sv ----
// caption routing, decode return and channel bridging
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - code 3: serial feeds out 1, ethernet out 2; A to serial, B to ethernet.
// - code 4: serial feeds both outputs; input A text to both host ports.
// - code 5: ethernet feeds both outputs; input B text to both host ports.
// - code 6: serial feeds both outputs; input B text to both host ports.
// - code 7: ethernet feeds both outputs; input A text to both host ports.
// - codes 8 and 9 decode A or B only, text to both host ports.
// - decoded text comes only from incoming streams, never from own insertion.
// - locked channel inserts received bytes into program and monitor at once.
// - serial port receives caption bytes and sends decoded text at once.
// - input A feeds odd outputs, input B feeds even outputs.
// - decoded text leaves host ports only while its input is locked.
// - bridging only when target frame rate is at least the source rate.
// - bridge 1, route 0: A captions copied to B once both locked, transcoded when i_hd_a and i_hd_b differ.
// - output 3 carries input A decoded captions as visible overlay.
// - bridge codes 1-6 pick direction and fields; 0 and 7-F bridge nothing.
module ccrb_caption_route_bridge (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // selector codes
    input wire logic [ccrb_pkg::CODE_W-1:0] i_route_select_code,
    input wire logic [ccrb_pkg::CODE_W-1:0] i_bridge_select_code,
    // video input status
    input wire logic i_lock_a,
    input wire logic i_lock_b,
    input wire logic [ccrb_pkg::RATE_W-1:0] i_rate_a,
    input wire logic [ccrb_pkg::RATE_W-1:0] i_rate_b,
    input wire logic i_hd_a,
    input wire logic i_hd_b,
    // captions extracted from incoming streams
    input wire logic [ccrb_pkg::BYTE_W-1:0] i_dec_a_data,
    input wire logic i_dec_a_valid,
    input wire logic i_dec_a_field,
    input wire logic [ccrb_pkg::BYTE_W-1:0] i_dec_b_data,
    input wire logic i_dec_b_valid,
    input wire logic i_dec_b_field,
    // host receive
    input wire logic [ccrb_pkg::BYTE_W-1:0] i_ser_rx_data,
    input wire logic i_ser_rx_valid,
    input wire logic [ccrb_pkg::BYTE_W-1:0] i_eth_rx_data,
    input wire logic i_eth_rx_valid,
    // host transmit
    output logic [ccrb_pkg::BYTE_W-1:0] o_ser_tx_data,
    output logic o_ser_tx_valid,
    output logic [ccrb_pkg::BYTE_W-1:0] o_eth_tx_data,
    output logic o_eth_tx_valid,
    // program and monitor insertion, channel A
    output logic [ccrb_pkg::BYTE_W-1:0] o_pgm1_data,
    output logic o_pgm1_valid,
    output logic o_pgm1_bridged,
    output logic o_pgm1_xcode,
    output logic [ccrb_pkg::BYTE_W-1:0] o_mon3_data,
    output logic o_mon3_valid,
    // program and monitor insertion, channel B
    output logic [ccrb_pkg::BYTE_W-1:0] o_pgm2_data,
    output logic o_pgm2_valid,
    output logic o_pgm2_bridged,
    output logic o_pgm2_xcode,
    output logic [ccrb_pkg::BYTE_W-1:0] o_mon4_data,
    output logic o_mon4_valid,
    // overlay and video routing
    output logic [ccrb_pkg::BYTE_W-1:0] o_ovl3_data,
    output logic o_ovl3_valid,
    output logic o_odd_from_a,
    output logic o_even_from_b
);
    import ccrb_pkg::*;

    ccrb_state_type st_q, st_d;
    ccrb_ins_src_type ins_src [NCH];
    ccrb_dec_src_type ser_dec, eth_dec;
    logic [NCH-1:0] lock;
    logic [NCH-1:0][RATE_W-1:0] rate;
    logic [NCH-1:0][BYTE_W-1:0] dec_data;
    logic [NCH-1:0] dec_vld;
    logic [NCH-1:0] brg_into, brg_fld_ok, brg_take;

    assign lock = {i_lock_b, i_lock_a};
    assign rate = {i_rate_b, i_rate_a};
    assign dec_data = {i_dec_b_data, i_dec_a_data};
    assign dec_vld = {i_dec_b_valid, i_dec_a_valid};

    // route-select decode
    always_comb begin
        ins_src[CH_A] = SRC_NONE;
        ins_src[CH_B] = SRC_NONE;
        ser_dec = DEC_NONE;
        eth_dec = DEC_NONE;
        case (i_route_select_code)
            ROUTE_ENC_SPLIT: begin
                ins_src[CH_A] = SRC_SER;
                ins_src[CH_B] = SRC_ETH;
            end
            ROUTE_ENC_SER: begin
                ins_src[CH_A] = SRC_SER;
                ins_src[CH_B] = SRC_SER;
            end
            ROUTE_ENC_ETH: begin
                ins_src[CH_A] = SRC_ETH;
                ins_src[CH_B] = SRC_ETH;
            end
            ROUTE_SPLIT: begin
                ins_src[CH_A] = SRC_SER;
                ins_src[CH_B] = SRC_ETH;
                ser_dec = DEC_A;
                eth_dec = DEC_B;
            end
            ROUTE_SER_A: begin
                ins_src[CH_A] = SRC_SER;
                ins_src[CH_B] = SRC_SER;
                ser_dec = DEC_A;
                eth_dec = DEC_A;
            end
            ROUTE_ETH_B: begin
                ins_src[CH_A] = SRC_ETH;
                ins_src[CH_B] = SRC_ETH;
                ser_dec = DEC_B;
                eth_dec = DEC_B;
            end
            ROUTE_SER_B: begin
                ins_src[CH_A] = SRC_SER;
                ins_src[CH_B] = SRC_SER;
                ser_dec = DEC_B;
                eth_dec = DEC_B;
            end
            ROUTE_ETH_A: begin
                ins_src[CH_A] = SRC_ETH;
                ins_src[CH_B] = SRC_ETH;
                ser_dec = DEC_A;
                eth_dec = DEC_A;
            end
            ROUTE_DEC_A: begin
                ser_dec = DEC_A;
                eth_dec = DEC_A;
            end
            ROUTE_DEC_B: begin
                ser_dec = DEC_B;
                eth_dec = DEC_B;
            end
            default: ser_dec = DEC_NONE;
        endcase
    end

    // bridge-select decode, index is the target channel
    always_comb begin
        brg_into = '0;
        brg_fld_ok = '0;
        case (i_bridge_select_code)
            BRG_AB: begin
                brg_into[CH_B] = 1'b1;
                brg_fld_ok[CH_B] = 1'b1;
            end
            BRG_BA: begin
                brg_into[CH_A] = 1'b1;
                brg_fld_ok[CH_A] = 1'b1;
            end
            BRG_AB_F1: begin
                brg_into[CH_B] = 1'b1;
                brg_fld_ok[CH_B] = (i_dec_a_field == FIELD_1);
            end
            BRG_BA_F1: begin
                brg_into[CH_A] = 1'b1;
                brg_fld_ok[CH_A] = (i_dec_b_field == FIELD_1);
            end
            BRG_AB_F2: begin
                brg_into[CH_B] = 1'b1;
                brg_fld_ok[CH_B] = (i_dec_a_field == FIELD_2);
            end
            BRG_BA_F2: begin
                brg_into[CH_A] = 1'b1;
                brg_fld_ok[CH_A] = (i_dec_b_field == FIELD_2);
            end
            default: brg_into = '0;
        endcase
    end

    // bridge takes the target slot when both locked and rate allows
    genvar gc;
    generate
        for (gc = 0; gc < NCH; gc++) begin : g_brg
            assign brg_take[gc] = brg_into[gc] && brg_fld_ok[gc]
                && lock[CH_A] && lock[CH_B]
                && (rate[gc] >= rate[NCH-1-gc])
                && dec_vld[NCH-1-gc];
        end
    endgenerate

    always_comb begin
        st_d = st_q;
        for (int c = 0; c < NCH; c++) begin
            st_d.ins_vld[c] = 1'b0;
            st_d.ins_brg[c] = 1'b0;
            st_d.ins_xcode[c] = 1'b0;
            if (brg_take[c]) begin
                st_d.ins_data[c] = dec_data[NCH-1-c];
                st_d.ins_vld[c] = 1'b1;
                st_d.ins_brg[c] = 1'b1;
                st_d.ins_xcode[c] = (i_hd_a != i_hd_b);
            end else if (lock[c] && ins_src[c] == SRC_SER
                         && i_ser_rx_valid) begin
                st_d.ins_data[c] = i_ser_rx_data;
                st_d.ins_vld[c] = 1'b1;
            end else if (lock[c] && ins_src[c] == SRC_ETH
                         && i_eth_rx_valid) begin
                st_d.ins_data[c] = i_eth_rx_data;
                st_d.ins_vld[c] = 1'b1;
            end
        end
        // decoded text only from the extractors, gated by lock
        st_d.ser_vld = 1'b0;
        if (ser_dec == DEC_A) begin
            st_d.ser_data = i_dec_a_data;
            st_d.ser_vld = i_dec_a_valid && i_lock_a;
        end else if (ser_dec == DEC_B) begin
            st_d.ser_data = i_dec_b_data;
            st_d.ser_vld = i_dec_b_valid && i_lock_b;
        end
        st_d.eth_vld = 1'b0;
        if (eth_dec == DEC_A) begin
            st_d.eth_data = i_dec_a_data;
            st_d.eth_vld = i_dec_a_valid && i_lock_a;
        end else if (eth_dec == DEC_B) begin
            st_d.eth_data = i_dec_b_data;
            st_d.eth_vld = i_dec_b_valid && i_lock_b;
        end
        // monitor overlay of input A captions
        st_d.ovl_vld = i_dec_a_valid && i_lock_a;
        if (i_dec_a_valid) begin
            st_d.ovl_data = i_dec_a_data;
        end
        st_d.odd_from_a = 1'b1;
        st_d.even_from_b = 1'b1;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs, monitor mirrors program
    assign o_ser_tx_data = st_q.ser_data;
    assign o_ser_tx_valid = st_q.ser_vld;
    assign o_eth_tx_data = st_q.eth_data;
    assign o_eth_tx_valid = st_q.eth_vld;
    assign o_pgm1_data = st_q.ins_data[CH_A];
    assign o_pgm1_valid = st_q.ins_vld[CH_A];
    assign o_pgm1_bridged = st_q.ins_brg[CH_A];
    assign o_pgm1_xcode = st_q.ins_xcode[CH_A];
    assign o_mon3_data = st_q.ins_data[CH_A];
    assign o_mon3_valid = st_q.ins_vld[CH_A];
    assign o_pgm2_data = st_q.ins_data[CH_B];
    assign o_pgm2_valid = st_q.ins_vld[CH_B];
    assign o_pgm2_bridged = st_q.ins_brg[CH_B];
    assign o_pgm2_xcode = st_q.ins_xcode[CH_B];
    assign o_mon4_data = st_q.ins_data[CH_B];
    assign o_mon4_valid = st_q.ins_vld[CH_B];
    assign o_ovl3_data = st_q.ovl_data;
    assign o_ovl3_valid = st_q.ovl_vld;
    assign o_odd_from_a = st_q.odd_from_a;
    assign o_even_from_b = st_q.even_from_b;

    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_srst);
    split_route_a: assert property (
        i_route_select_code == ROUTE_SPLIT && i_lock_b && i_eth_rx_valid
        && !brg_take[CH_B] |=> o_pgm2_valid && !o_pgm2_bridged
        && o_pgm2_data == $past(i_eth_rx_data)
        && o_ser_tx_valid == $past(i_dec_a_valid && i_lock_a))
        else $error("route 3 channel B or serial return wrong");
    ser_both_a: assert property (
        i_route_select_code == ROUTE_SER_A && i_lock_b && i_ser_rx_valid
        && !brg_take[CH_B] && i_dec_a_valid && i_lock_a
        |=> o_pgm2_data == $past(i_ser_rx_data)
        && o_eth_tx_valid && o_eth_tx_data == $past(i_dec_a_data))
        else $error("route 4 routing wrong");
    eth_both_a: assert property (
        i_route_select_code == ROUTE_ETH_B && i_lock_a && i_eth_rx_valid
        && !brg_take[CH_A] && i_dec_b_valid && i_lock_b
        |=> o_pgm1_data == $past(i_eth_rx_data)
        && o_ser_tx_valid && o_ser_tx_data == $past(i_dec_b_data))
        else $error("route 5 routing wrong");
    ser_b_dec_a: assert property (
        i_route_select_code == ROUTE_SER_B && i_dec_b_valid && i_lock_b
        |=> o_eth_tx_valid && o_eth_tx_data == $past(i_dec_b_data))
        else $error("route 6 return wrong");
    eth_a_dec_a: assert property (
        i_route_select_code == ROUTE_ETH_A && i_dec_a_valid && i_lock_a
        |=> o_ser_tx_valid && o_ser_tx_data == $past(i_dec_a_data))
        else $error("route 7 return wrong");
    dec_only_a: assert property (
        i_route_select_code == ROUTE_DEC_B && !brg_take[CH_A]
        |=> !o_pgm1_valid && o_ser_tx_valid == o_eth_tx_valid)
        else $error("decode-only mode inserted or split text");
    unlock_quiet_a: assert property (
        i_route_select_code == ROUTE_DEC_A && !i_lock_a
        |=> !o_ser_tx_valid && !o_eth_tx_valid)
        else $error("decoded text while unlocked");
    rate_block_a: assert property (
        i_rate_b < i_rate_a && !brg_into[CH_A] |=> !o_pgm2_bridged)
        else $error("bridge into slower target");
    bridge_ab_a: assert property (
        i_bridge_select_code == BRG_AB && i_lock_a && i_lock_b
        && i_dec_a_valid && i_rate_b >= i_rate_a
        |=> o_pgm2_bridged && o_mon4_data == $past(i_dec_a_data)
        && o_pgm2_xcode == $past(i_hd_a != i_hd_b))
        else $error("bridge A to B missing");
    field_sel_a: assert property (
        i_bridge_select_code == BRG_AB_F1 && i_dec_a_field == FIELD_2
        |=> !o_pgm2_bridged)
        else $error("field 2 bridged under field 1 code");
    overlay_a: assert property (
        i_dec_a_valid && i_lock_a
        |=> o_ovl3_valid && o_ovl3_data == $past(i_dec_a_data))
        else $error("overlay missing");
    undef_route_a: assert property (
        i_route_select_code > ROUTE_DEC_B && brg_into == '0
        |=> !o_ser_tx_valid && !o_eth_tx_valid && !o_pgm1_valid)
        else $error("undefined route code active");
    vid_route_a: assert property (
        !i_srst |=> o_odd_from_a && o_even_from_b)
        else $error("video routing flags wrong");

endmodule

`default_nettype wire

// ---- sim/ccrb_host_model.sv ----
// host pc model on the serial and ethernet ports
`timescale 1ns/1ns
`default_nettype none

module ccrb_host_model (
    // clock
    input wire logic i_clk,
    // bytes sent to the card
    output logic [7:0] o_ser_rx_data,
    output logic o_ser_rx_valid,
    output logic [7:0] o_eth_rx_data,
    output logic o_eth_rx_valid,
    // bytes received from the card
    input wire logic [7:0] i_ser_tx_data,
    input wire logic i_ser_tx_valid,
    input wire logic [7:0] i_eth_tx_data,
    input wire logic i_eth_tx_valid
);
    int ser_got = 0;
    int eth_got = 0;
    logic [7:0] ser_last = 8'h00;

    initial begin
        o_ser_rx_data = 8'h00;
        o_ser_rx_valid = 1'b0;
        o_eth_rx_data = 8'h00;
        o_eth_rx_valid = 1'b0;
    end

    // send serial and ethernet bytes in the same cycle
    task automatic put(input logic [7:0] sd, input logic sv,
                       input logic [7:0] ed, input logic ev);
        o_ser_rx_data <= sd;
        o_ser_rx_valid <= sv;
        o_eth_rx_data <= ed;
        o_eth_rx_valid <= ev;
    endtask

    // released lines show the inverse of the last byte
    task automatic idle();
        o_ser_rx_valid <= 1'b0;
        o_eth_rx_valid <= 1'b0;
        o_ser_rx_data <= ~o_ser_rx_data;
        o_eth_rx_data <= ~o_eth_rx_data;
    endtask

    // decoded text arriving at the host
    always @(posedge i_clk) begin
        if (i_ser_tx_valid === 1'b1) begin
            ser_got <= ser_got + 1;
            ser_last <= i_ser_tx_data;
        end
        if (i_eth_tx_valid === 1'b1) begin
            eth_got <= eth_got + 1;
        end
    end
endmodule

`default_nettype wire

// ---- sim/ccrb_caption_route_bridge_bench.sv ----
// testbench for the caption route and bridge controller
`timescale 1ns/1ns
`default_nettype none

module ccrb_caption_route_bridge_bench;
    import ccrb_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] route = 4'h0, bridge = 4'h0;
    logic lock_a = 1'b1, lock_b = 1'b1, hd_a = 1'b0, hd_b = 1'b0;
    logic [2:0] rate_a = 3'h3, rate_b = 3'h3;
    logic [7:0] da_d = 8'h00, db_d = 8'h00;
    logic da_v = 1'b0, db_v = 1'b0, da_f = 1'b0, db_f = 1'b0;
    logic [7:0] srx_d, erx_d, stx_d, etx_d, p1_d, m3_d, p2_d, m4_d, ov_d;
    logic srx_v, erx_v, stx_v, etx_v, p1_v, p1_b, p1_x, m3_v;
    logic p2_v, p2_b, p2_x, m4_v, ov_v, odd, even;
    int miscompares = 0;
    int n_compared = 0;

    always #20 clk = ~clk;

    ccrb_caption_route_bridge i_ccrb_caption_route_bridge (
        .i_clk(clk), .i_srst(srst),
        .i_route_select_code(route), .i_bridge_select_code(bridge),
        .i_lock_a(lock_a), .i_lock_b(lock_b),
        .i_rate_a(rate_a), .i_rate_b(rate_b), .i_hd_a(hd_a), .i_hd_b(hd_b),
        .i_dec_a_data(da_d), .i_dec_a_valid(da_v), .i_dec_a_field(da_f),
        .i_dec_b_data(db_d), .i_dec_b_valid(db_v), .i_dec_b_field(db_f),
        .i_ser_rx_data(srx_d), .i_ser_rx_valid(srx_v),
        .i_eth_rx_data(erx_d), .i_eth_rx_valid(erx_v),
        .o_ser_tx_data(stx_d), .o_ser_tx_valid(stx_v),
        .o_eth_tx_data(etx_d), .o_eth_tx_valid(etx_v),
        .o_pgm1_data(p1_d), .o_pgm1_valid(p1_v), .o_pgm1_bridged(p1_b),
        .o_pgm1_xcode(p1_x), .o_mon3_data(m3_d), .o_mon3_valid(m3_v),
        .o_pgm2_data(p2_d), .o_pgm2_valid(p2_v), .o_pgm2_bridged(p2_b),
        .o_pgm2_xcode(p2_x), .o_mon4_data(m4_d), .o_mon4_valid(m4_v),
        .o_ovl3_data(ov_d), .o_ovl3_valid(ov_v),
        .o_odd_from_a(odd), .o_even_from_b(even)
    );

    ccrb_host_model i_ccrb_host_model (
        .i_clk(clk),
        .o_ser_rx_data(srx_d), .o_ser_rx_valid(srx_v),
        .o_eth_rx_data(erx_d), .o_eth_rx_valid(erx_v),
        .i_ser_tx_data(stx_d), .i_ser_tx_valid(stx_v),
        .i_eth_tx_data(etx_d), .i_eth_tx_valid(etx_v)
    );

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // one cycle of host and decoder bytes, outputs checked one edge later
    task automatic step(input logic [7:0] sd, input logic sv,
                        input logic [7:0] ed, input logic ev,
                        input logic [7:0] ad, input logic av, input logic af,
                        input logic [7:0] bd, input logic bv, input logic bf);
        @(posedge clk);
        i_ccrb_host_model.put(sd, sv, ed, ev);
        da_d <= ad;
        da_v <= av;
        da_f <= af;
        db_d <= bd;
        db_v <= bv;
        db_f <= bf;
        @(posedge clk);
        i_ccrb_host_model.idle();
        da_v <= 1'b0;
        db_v <= 1'b0;
        da_d <= ~ad;
        db_d <= ~bd;
        #1;
    endtask

    // {ser->1, eth->1, ser->2, eth->2, a->ser, b->ser, a->eth, b->eth}
    function automatic logic [7:0] route_map(input logic [3:0] c);
        case (c)
            4'h0: return 8'b1001_0000;
            4'h1: return 8'b1010_0000;
            4'h2: return 8'b0101_0000;
            4'h3: return 8'b1001_1001;
            4'h4: return 8'b1010_1010;
            4'h5: return 8'b0101_0101;
            4'h6: return 8'b1010_0101;
            4'h7: return 8'b0101_1010;
            4'h8: return 8'b0000_1010;
            4'h9: return 8'b0000_0101;
            default: return 8'h00;
        endcase
    endfunction

    task automatic t_reset();
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk({stx_v, etx_v, p1_v, p2_v, ov_v, odd, even}, 16'h0000);
        repeat (2) @(posedge clk);
        #1;
        chk({odd, even}, 16'h0003);
    endtask

    task automatic t_routes();
        logic [7:0] m;
        logic [7:0] sd, ed, ad, bd;
        for (int c = 0; c < 16; c++) begin
            @(posedge clk);
            route <= 4'(c);
            m = route_map(4'(c));
            sd = {4'h1, 4'(c)};
            ed = {4'h3, 4'(c)};
            ad = {4'h5, 4'(c)};
            bd = {4'h7, 4'(c)};
            step(sd, 1'b1, ed, 1'b1, ad, 1'b1, 1'b0, bd, 1'b1, 1'b0);
            chk({p1_v, m3_v, p2_v, m4_v},
                {{2{m[7] | m[6]}}, {2{m[5] | m[4]}}});
            if (m[7] | m[6]) chk({p1_d, m3_d}, {2{m[7] ? sd : ed}});
            if (m[5] | m[4]) chk({p2_d, m4_d}, {2{m[5] ? sd : ed}});
            chk({stx_v, etx_v},
                {m[3] | m[2], m[1] | m[0]});
            if (m[3] | m[2]) chk(stx_d, m[3] ? ad : bd);
            if (m[1] | m[0]) chk(etx_d, m[1] ? ad : bd);
            chk({ov_v, ov_d}, {1'b1, ad});
        end
    endtask

    task automatic t_unlocked();
        @(posedge clk);
        lock_a <= 1'b0;
        route <= ROUTE_DEC_A;
        step(8'h00, 1'b0, 8'h00, 1'b0, 8'hC3, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
        chk({stx_v, etx_v, ov_v}, 16'h0000);
        @(posedge clk);
        route <= ROUTE_ENC_SER;
        step(8'h3C, 1'b1, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
        chk({p1_v, p2_v, p2_d}, {2'b01, 8'h3C});
        @(posedge clk);
        lock_a <= 1'b1;
    endtask

    task automatic t_bridge();
        logic ab, ba;
        @(posedge clk);
        route <= 4'hA;
        hd_a <= 1'b1;
        for (int c = 0; c < 16; c++) begin
            @(posedge clk);
            bridge <= 4'(c);
            for (int f = 0; f < 2; f++) begin
                ab = (c == 1) || (c == 3 && f == 0) || (c == 5 && f == 1);
                ba = (c == 2) || (c == 4 && f == 0) || (c == 6 && f == 1);
                step(8'h00, 1'b0, 8'h00, 1'b0, {4'h9, 4'(c)}, 1'b1, 1'(f),
                     {4'hB, 4'(c)}, 1'b1, 1'(f));
                chk({p2_v, p2_b, p2_x, m4_v}, {4{ab}});
                chk({p1_v, p1_b, p1_x, m3_v}, {4{ba}});
                if (ab) chk(p2_d, {4'h9, 4'(c)});
                if (ba) chk(p1_d, {4'hB, 4'(c)});
            end
        end
        @(posedge clk);
        hd_a <= 1'b0;
    endtask

    task automatic t_rate();
        @(posedge clk);
        bridge <= BRG_AB;
        for (int r = 2; r < 5; r++) begin
            @(posedge clk);
            rate_b <= 3'(r);
            step(8'h00, 1'b0, 8'h00, 1'b0, 8'h66, 1'b1, 1'b0,
                 8'h00, 1'b0, 1'b0);
            chk({p2_v, p2_b, p2_x}, {{2{r >= 3}}, 1'b0});
        end
        @(posedge clk);
        lock_b <= 1'b0;
        step(8'h00, 1'b0, 8'h00, 1'b0, 8'h67, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
        chk({p2_v, m4_v}, 16'h0000);
        @(posedge clk);
        lock_b <= 1'b1;
        bridge <= BRG_NONE;
    endtask

    initial begin
        #(40 * 2000);
        miscompares++;
        end_of_test();
    end

    initial begin
        t_reset();
        t_routes();
        t_unlocked();
        t_bridge();
        t_rate();
        chk(16'(i_ccrb_host_model.ser_got), 16'h0007);
        chk(16'(i_ccrb_host_model.eth_got), 16'h0007);
        chk(16'(i_ccrb_host_model.ser_last), 16'h0079);
        end_of_test();
    end
endmodule

`default_nettype wire
